/* hdl/utf_pkg.sv */
// constants for the usb transmit fifo status block
package utf_pkg;
   // fifo geometry
   localparam int          DEPTH      = 16;
   localparam int          AW         = 4;
   localparam int          PW         = AW + 1;
   localparam int          CW         = 5;
   // bus geometry
   localparam int          BUS_AW     = 8;
   localparam int          BUS_DW     = 32;
   // register byte offsets
   localparam logic [7:0]  OFF_FLAG   = 8'h00;
   localparam logic [7:0]  OFF_DATA   = 8'h04;
   localparam logic [7:0]  OFF_COUNT  = 8'h08;
   localparam logic [7:0]  OFF_CTRL   = 8'h0C;
   localparam logic [7:0]  OFF_ISTAT  = 8'h10;
   localparam logic [7:0]  OFF_IMASK  = 8'h14;
   // flag register fields
   localparam int          FB_OVF     = 0;
   localparam int          FB_URF     = 1;
   localparam int          FB_FULL    = 2;
   localparam int          FB_EMPTY   = 3;
   localparam int          FB_INDEX   = 6;
   // control register fields
   localparam int          CB_CLEAR   = 0;
   // interrupt status fields
   localparam int          IB_OVF     = 0;
   localparam int          IB_URF     = 1;
   localparam int          IB_SENT    = 2;
   localparam int          IW         = 3;
   // reset values
   localparam logic [PW-1:0] PTR_RST  = 5'h00;
   localparam logic [CW-1:0] CNT_RST  = 5'h00;
   localparam logic [IW-1:0] IMASK_RST = 3'h0;
   // bus responses
   localparam logic [1:0]  RESP_OKAY  = 2'h0;
   localparam logic [1:0]  RESP_SLV   = 2'h2;
endpackage

/* hdl/utf_tx_fifo.sv */
// usb transmit fifo with status flags, error locking and axi4-lite registers
//
// Behaviour
// - byte count write sets the packet-present index flag
// - read marker advance clears the packet-present index flag
// - empty flag when write pointer equals read pointer and write marker, no rollover
// - empty flag is live, not sticky, in every mode
// - full flag live while write pointer rolled over and equals read pointer
// - underrun set on a read from empty fifo or beyond byte count
// - underrun set when byte count disagrees with bytes written
// - underrun stays set until firmware clears it
// - on underrun the read pointer holds at the empty position; here a rewind still reloads it from the read marker
// - while underrun or overrun is set every in request gets nak
// - overrun set when firmware writes a byte into a full fifo
// - overrun set on byte count write while index flag is one
// - overrun stays set until firmware clears it
// - on overrun the write pointer holds at the full position
// - flag bits 5 and 4 reserved; write zero, read back zero here
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module utf_tx_fifo (
   // clock and reset
   input  wire logic                      CLK,
   input  wire logic                      RST_N,
   // axi4-lite write address and data
   input  wire logic [utf_pkg::BUS_AW-1:0] AWADDR,
   input  wire logic                      AWVALID,
   output logic                           AWREADY,
   input  wire logic [utf_pkg::BUS_DW-1:0] WDATA,
   input  wire logic [3:0]                WSTRB,
   input  wire logic                      WVALID,
   output logic                           WREADY,
   // axi4-lite write response
   output logic [1:0]                     BRESP,
   output logic                           BVALID,
   input  wire logic                      BREADY,
   // axi4-lite read
   input  wire logic [utf_pkg::BUS_AW-1:0] ARADDR,
   input  wire logic                      ARVALID,
   output logic                           ARREADY,
   output logic [utf_pkg::BUS_DW-1:0]     RDATA,
   output logic [1:0]                     RRESP,
   output logic                           RVALID,
   input  wire logic                      RREADY,
   // serial interface engine side
   input  wire logic                      SIE_RD,
   output logic [7:0]                     SIE_DATA,
   input  wire logic                      SIE_ADVANCE,
   input  wire logic                      SIE_REWIND,
   input  wire logic                      SIE_IN_REQ,
   output logic                           TX_NAK,
   output logic                           TX_SEND,
   // interrupt
   output logic                           IRQ
);

   function automatic logic hit(input logic [utf_pkg::BUS_AW-1:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   function automatic logic mapped(input logic [utf_pkg::BUS_AW-1:0] a);
      mapped = hit(a, utf_pkg::OFF_FLAG) || hit(a, utf_pkg::OFF_DATA)
            || hit(a, utf_pkg::OFF_COUNT) || hit(a, utf_pkg::OFF_CTRL)
            || hit(a, utf_pkg::OFF_ISTAT) || hit(a, utf_pkg::OFF_IMASK);
   endfunction

   // bus slave state
   logic                          aw_full;
   logic [utf_pkg::BUS_AW-1:0]    aw_addr;
   logic                          w_full;
   logic [utf_pkg::BUS_DW-1:0]    w_data;
   logic                          w_lane0;
   logic                          do_write;
   logic                          next_aw_full;
   logic                          next_w_full;

   // fifo state
   logic [7:0]                    mem [utf_pkg::DEPTH];
   logic [utf_pkg::PW-1:0]        wp;
   logic [utf_pkg::PW-1:0]        rp;
   logic [utf_pkg::PW-1:0]        wm;
   logic [utf_pkg::PW-1:0]        rm;
   logic [utf_pkg::CW-1:0]        byte_count;
   logic [utf_pkg::CW-1:0]        remain;
   logic                          index;
   logic                          urf;
   logic                          ovf;
   logic [utf_pkg::IW-1:0]        istat;
   logic [utf_pkg::IW-1:0]        imask;

   // decoded events
   logic                          wr_ok;
   logic                          clr;
   logic                          push;
   logic                          cnt_wr;
   logic                          flag_wr;
   logic                          pop;
   logic                          adv;
   logic                          rew;
   logic                          empty_flag;
   logic                          full_flag;
   logic                          rd_blocked;
   logic                          wr_blocked;
   logic [utf_pkg::CW-1:0]        written;
   logic                          urf_set;
   logic                          ovf_set;
   logic [utf_pkg::IW-1:0]        ev;
   logic [utf_pkg::IW-1:0]        next_istat;
   logic                          err;

   // ---------------- axi4-lite write path ----------------
   assign do_write     = aw_full && w_full && !BVALID;
   assign next_aw_full = do_write ? 1'b0 : (aw_full || (AWVALID && AWREADY));
   assign next_w_full  = do_write ? 1'b0 : (w_full || (WVALID && WREADY));

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         aw_full <= 1'b0;
         aw_addr <= '0;
         AWREADY <= 1'b0;
      end else begin
         aw_full <= next_aw_full;
         AWREADY <= !next_aw_full;
         if (AWVALID && AWREADY) begin
            aw_addr <= AWADDR;
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         w_full  <= 1'b0;
         w_data  <= '0;
         w_lane0 <= 1'b0;
         WREADY  <= 1'b0;
      end else begin
         w_full <= next_w_full;
         WREADY <= !next_w_full;
         if (WVALID && WREADY) begin
            w_data  <= WDATA;
            w_lane0 <= WSTRB[0];
         end
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         BVALID <= 1'b0;
         BRESP  <= utf_pkg::RESP_OKAY;
      end else if (do_write) begin
         BVALID <= 1'b1;
         BRESP  <= mapped(aw_addr) ? utf_pkg::RESP_OKAY : utf_pkg::RESP_SLV;
      end else if (BREADY) begin
         BVALID <= 1'b0;
      end
   end

   // all fields live in byte lane 0, so a write without it changes nothing
   assign wr_ok   = do_write && w_lane0;
   assign clr     = wr_ok && hit(aw_addr, utf_pkg::OFF_CTRL) && w_data[utf_pkg::CB_CLEAR];
   assign push    = wr_ok && hit(aw_addr, utf_pkg::OFF_DATA);
   assign cnt_wr  = wr_ok && hit(aw_addr, utf_pkg::OFF_COUNT);
   assign flag_wr = wr_ok && hit(aw_addr, utf_pkg::OFF_FLAG);
   assign pop     = SIE_RD;
   assign adv     = SIE_ADVANCE;
   assign rew     = SIE_REWIND;

   // ---------------- fifo status ----------------
   assign empty_flag = (wp == rp) && (wp == wm);
   assign full_flag  = (wp[utf_pkg::AW-1:0] == rp[utf_pkg::AW-1:0])
                    && (wp[utf_pkg::AW] != rp[utf_pkg::AW]);
   // reads stop at the committed packet end, not only at the write pointer
   assign rd_blocked = urf || (rp == wm) || (remain == '0);
   assign wr_blocked = ovf || full_flag;
   assign written    = wp - wm;
   assign err        = urf || ovf;

   assign urf_set = (pop && rd_blocked)
                 || (cnt_wr && !index && (w_data[utf_pkg::CW-1:0] != written))
                 || (adv && !index);
   assign ovf_set = (push && wr_blocked)
                 || (cnt_wr && index);

   always_ff @(posedge CLK) begin
      if (push && !wr_blocked) begin
         mem[wp[utf_pkg::AW-1:0]] <= w_data[7:0];
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wp <= utf_pkg::PTR_RST;
      end else if (clr) begin
         wp <= utf_pkg::PTR_RST;
      end else if (push && !wr_blocked) begin
         wp <= wp + 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rp     <= utf_pkg::PTR_RST;
         remain <= utf_pkg::CNT_RST;
      end else if (clr) begin
         rp     <= utf_pkg::PTR_RST;
         remain <= utf_pkg::CNT_RST;
      end else if (rew) begin
         rp     <= rm;
         remain <= byte_count;
      end else if (cnt_wr && !index) begin
         remain <= w_data[utf_pkg::CW-1:0];
      end else if (pop && !rd_blocked) begin
         rp     <= rp + 1'b1;
         remain <= remain - 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         wm         <= utf_pkg::PTR_RST;
         byte_count <= utf_pkg::CNT_RST;
      end else if (clr) begin
         wm         <= utf_pkg::PTR_RST;
         byte_count <= utf_pkg::CNT_RST;
      end else if (cnt_wr && !index) begin
         wm         <= wp;
         byte_count <= w_data[utf_pkg::CW-1:0];
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rm <= utf_pkg::PTR_RST;
      end else if (clr) begin
         rm <= utf_pkg::PTR_RST;
      end else if (adv) begin
         rm <= rp;
      end
   end

   // a count write in the same cycle as an advance leaves a packet queued
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         index <= 1'b0;
      end else if (clr) begin
         index <= 1'b0;
      end else if (cnt_wr) begin
         index <= 1'b1;
      end else if (adv) begin
         index <= 1'b0;
      end
   end

   // set wins over a flag-register clear in the same cycle; the control clear wins over set
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         urf <= 1'b0;
         ovf <= 1'b0;
      end else if (clr) begin
         urf <= 1'b0;
         ovf <= 1'b0;
      end else begin
         if (urf_set) begin
            urf <= 1'b1;
         end else if (flag_wr && w_data[utf_pkg::FB_URF]) begin
            urf <= 1'b0;
         end
         if (ovf_set) begin
            ovf <= 1'b1;
         end else if (flag_wr && w_data[utf_pkg::FB_OVF]) begin
            ovf <= 1'b0;
         end
      end
   end

   // ---------------- sie answers ----------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SIE_DATA <= 8'h00;
         TX_NAK   <= 1'b0;
         TX_SEND  <= 1'b0;
      end else begin
         if (pop && !rd_blocked) begin
            SIE_DATA <= mem[rp[utf_pkg::AW-1:0]];
         end
         TX_NAK  <= SIE_IN_REQ && (err || !index);
         TX_SEND <= SIE_IN_REQ && !err && index;
      end
   end

   // ---------------- interrupts ----------------
   always_comb begin
      ev                   = '0;
      ev[utf_pkg::IB_OVF]  = ovf_set && !clr;
      ev[utf_pkg::IB_URF]  = urf_set && !clr;
      ev[utf_pkg::IB_SENT] = adv && index && !clr;
      next_istat = istat;
      if (wr_ok && hit(aw_addr, utf_pkg::OFF_ISTAT)) begin
         next_istat = istat & ~w_data[utf_pkg::IW-1:0];
      end
      next_istat = next_istat | ev;
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         istat <= '0;
         imask <= utf_pkg::IMASK_RST;
         IRQ   <= 1'b0;
      end else begin
         istat <= next_istat;
         IRQ   <= |(next_istat & imask);
         if (wr_ok && hit(aw_addr, utf_pkg::OFF_IMASK)) begin
            imask <= w_data[utf_pkg::IW-1:0];
         end
      end
   end

   // ---------------- axi4-lite read path ----------------
   function automatic logic [utf_pkg::BUS_DW-1:0] rd_mux(input logic [utf_pkg::BUS_AW-1:0] a);
      rd_mux = '0;
      if (hit(a, utf_pkg::OFF_FLAG)) begin
         // bits 5 and 4 read as zero
         rd_mux[utf_pkg::FB_OVF]   = ovf;
         rd_mux[utf_pkg::FB_URF]   = urf;
         rd_mux[utf_pkg::FB_FULL]  = full_flag;
         rd_mux[utf_pkg::FB_EMPTY] = empty_flag;
         rd_mux[utf_pkg::FB_INDEX] = index;
      end else if (hit(a, utf_pkg::OFF_COUNT)) begin
         rd_mux[utf_pkg::CW-1:0] = byte_count;
      end else if (hit(a, utf_pkg::OFF_ISTAT)) begin
         rd_mux[utf_pkg::IW-1:0] = istat;
      end else if (hit(a, utf_pkg::OFF_IMASK)) begin
         rd_mux[utf_pkg::IW-1:0] = imask;
      end
   endfunction

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b0;
         RDATA   <= '0;
         RRESP   <= utf_pkg::RESP_OKAY;
      end else if (ARVALID && ARREADY) begin
         ARREADY <= 1'b0;
         RVALID  <= 1'b1;
         RDATA   <= rd_mux(ARADDR);
         RRESP   <= mapped(ARADDR) ? utf_pkg::RESP_OKAY : utf_pkg::RESP_SLV;
      end else if (RVALID && RREADY) begin
         RVALID  <= 1'b0;
         ARREADY <= 1'b1;
      end else if (!RVALID) begin
         ARREADY <= 1'b1;
      end
   end

   // ---------------- checks ----------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   property p_idx_set;
      cnt_wr && !clr |=> index;
   endproperty
   a_idx_set: assert property (p_idx_set) else $error("index not set by count write");

   property p_idx_clr;
      adv && !cnt_wr && !clr |=> !index;
   endproperty
   a_idx_clr: assert property (p_idx_clr) else $error("index not cleared by advance");

   property p_clear;
      clr |=> empty_flag && !full_flag && !urf && !ovf && !index;
   endproperty
   a_clear: assert property (p_clear) else $error("clear left fifo not empty");

   property p_full_excl;
      full_flag |-> !empty_flag && (wp != wm || rp != wp);
   endproperty
   a_full_excl: assert property (p_full_excl) else $error("full and empty together");

   // full must drop as soon as a byte leaves, since writes are refused while full
   property p_full_drop;
      full_flag && pop && !rd_blocked && !rew && !clr |=> !full_flag;
   endproperty
   a_full_drop: assert property (p_full_drop) else $error("full flag stuck after read");

   property p_empty_set;
      pop && !rd_blocked && !push && !clr && !rew && (rp + 1'b1 == wp) && (wp == wm)
         |=> empty_flag;
   endproperty
   a_empty_set: assert property (p_empty_set) else $error("empty flag not raised");

   property p_urf_rd;
      pop && rd_blocked && !clr && !rew |=> urf && $stable(rp);
   endproperty
   a_urf_rd: assert property (p_urf_rd) else $error("underrun read not caught");

   property p_mismatch;
      cnt_wr && !index && !clr && (w_data[utf_pkg::CW-1:0] != written) |=> urf;
   endproperty
   a_mismatch: assert property (p_mismatch) else $error("count mismatch not flagged");

   property p_urf_hold;
      urf && !clr && !(flag_wr && w_data[utf_pkg::FB_URF]) |=> urf;
   endproperty
   a_urf_hold: assert property (p_urf_hold) else $error("underrun dropped");

   property p_urf_lock;
      urf && !clr && !rew |=> $stable(rp);
   endproperty
   a_urf_lock: assert property (p_urf_lock) else $error("read pointer moved in underrun");

   property p_nak;
      SIE_IN_REQ && err |=> TX_NAK && !TX_SEND;
   endproperty
   a_nak: assert property (p_nak) else $error("in request not nakked");

   property p_ovf_wr;
      push && full_flag && !clr |=> ovf && $stable(wp) ##1 $stable(wp) || clr;
   endproperty
   a_ovf_wr: assert property (p_ovf_wr) else $error("overrun write not caught");

   property p_ovf_cnt;
      cnt_wr && index && !clr |=> ovf && index;
   endproperty
   a_ovf_cnt: assert property (p_ovf_cnt) else $error("count overrun not caught");

   property p_ovf_hold;
      ovf && !clr && !(flag_wr && w_data[utf_pkg::FB_OVF]) |=> ovf && $stable(wp);
   endproperty
   a_ovf_hold: assert property (p_ovf_hold) else $error("overrun dropped or pointer moved");

   property p_adv_idle;
      adv && !index && !cnt_wr && !clr |=> urf && !index;
   endproperty
   a_adv_idle: assert property (p_adv_idle) else $error("idle advance not flagged");

   c_send: cover property (SIE_IN_REQ && index && !err ##1 TX_SEND);
   c_full: cover property (full_flag);
   c_ovf:  cover property (push && full_flag ##1 ovf);
   c_irq:  cover property (!IRQ ##1 IRQ);

endmodule

/* verif/utf_sie_model.sv */
// serial engine stand-in: byte reads, marker advance, rewind, in-tokens
`timescale 1ns/1ps
module utf_sie_model (
   // clock
   input  wire logic       CLK,
   // from the fifo
   input  wire logic [7:0] SIE_DATA,
   input  wire logic       TX_NAK,
   input  wire logic       TX_SEND,
   // to the fifo
   output logic            SIE_RD,
   output logic            SIE_ADVANCE,
   output logic            SIE_REWIND,
   output logic            SIE_IN_REQ
);
   initial {SIE_RD, SIE_ADVANCE, SIE_REWIND, SIE_IN_REQ} = 4'h0;

   // gap idles the engine first; answers sampled after the reply edge
   task automatic op(input logic [3:0] k, input int gap,
                     output logic [7:0] d, output logic [1:0] hs);
      repeat (gap) @(posedge CLK);
      @(posedge CLK);
      {SIE_RD, SIE_ADVANCE, SIE_REWIND, SIE_IN_REQ} <= k;
      @(posedge CLK);
      {SIE_RD, SIE_ADVANCE, SIE_REWIND, SIE_IN_REQ} <= 4'h0;
      #1;
      d  = SIE_DATA;
      hs = {TX_NAK, TX_SEND};
   endtask
endmodule

/* verif/usb_tx_fifo_status_flags_tb.sv */
// self-checking bench for the usb transmit fifo status block
`timescale 1ns/1ps
module usb_tx_fifo_status_flags_tb;
   logic        CLK, RST_N;
   logic [7:0]  AWADDR, ARADDR, SIE_DATA, d;
   logic [31:0] WDATA, RDATA, q;
   logic [3:0]  WSTRB;
   logic        AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic        ARVALID, ARREADY, RVALID, RREADY, IRQ;
   logic        SIE_RD, SIE_ADVANCE, SIE_REWIND, SIE_IN_REQ, TX_NAK, TX_SEND;
   logic [1:0]  BRESP, RRESP, r, hs;
   int          failures, total_checks;
   localparam logic [3:0] RD = 4'h8, ADV = 4'h4, REW = 4'h2, INQ = 4'h1;
   localparam logic [7:0] FLG = 8'h00, DAT = 8'h04, CNT = 8'h08;
   localparam logic [7:0] CTL = 8'h0C, IST = 8'h10, IMK = 8'h14;

   typedef struct packed {
      logic        w;
      logic [7:0]  a;
      logic [31:0] v;
      logic [31:0] e;
      logic [1:0]  s;
   } utf_row_s;

   utf_row_s rows [13] = '{
      '{1'b0, FLG, 32'h0, 32'h08, 2'h0},
      '{1'b0, IMK, 32'h0, 32'h00, 2'h0},
      '{1'b0, IST, 32'h0, 32'h00, 2'h0},
      '{1'b1, DAT, 32'hA1, 32'h0, 2'h0},
      '{1'b0, FLG, 32'h0, 32'h00, 2'h0},
      '{1'b1, DAT, 32'hB2, 32'h0, 2'h0},
      '{1'b1, CNT, 32'h2, 32'h0, 2'h0},
      '{1'b0, FLG, 32'h0, 32'h40, 2'h0},
      '{1'b0, CNT, 32'h0, 32'h02, 2'h0},
      '{1'b1, 8'h1C, 32'h0, 32'h0, 2'h2},
      '{1'b0, 8'h1C, 32'h0, 32'h00, 2'h2},
      '{1'b0, DAT, 32'h0, 32'h00, 2'h0},
      '{1'b0, CTL, 32'h0, 32'h00, 2'h0}
   };

   utf_tx_fifo utf_tx_fifo_inst (
      .CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB,
      .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR, .ARVALID,
      .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .SIE_RD, .SIE_DATA,
      .SIE_ADVANCE, .SIE_REWIND, .SIE_IN_REQ, .TX_NAK, .TX_SEND, .IRQ
   );

   utf_sie_model utf_sie_model_inst (
      .CLK, .SIE_DATA, .TX_NAK, .TX_SEND, .SIE_RD, .SIE_ADVANCE,
      .SIE_REWIND, .SIE_IN_REQ
   );

   initial begin
      CLK = 1'b0;
      forever #25 CLK = ~CLK;
   end

   task automatic chk(input logic [31:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   task automatic close_out;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // address and data offered together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge CLK);
      AWADDR  <= a;
      WDATA   <= v;
      AWVALID <= 1'b1;
      WVALID  <= 1'b1;
      BREADY  <= 1'b1;
      fork
         begin
            do @(posedge CLK); while (!AWREADY);
            AWVALID <= 1'b0;
         end
         begin
            do @(posedge CLK); while (!WREADY);
            WVALID <= 1'b0;
         end
      join
      do @(posedge CLK); while (!BVALID);
      r = BRESP;
      BREADY <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge CLK);
      ARADDR  <= a;
      ARVALID <= 1'b1;
      RREADY  <= 1'b1;
      do @(posedge CLK); while (!ARREADY);
      ARVALID <= 1'b0;
      do @(posedge CLK); while (!RVALID);
      q = RDATA;
      r = RRESP;
      RREADY <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
      rd(a);
      chk(q & m, e, "register");
   endtask

   task automatic so(input logic [3:0] k, input int gap);
      utf_sie_model_inst.op(k, gap, d, hs);
   endtask

   task automatic ck_irq(input logic e);
      @(posedge CLK);
      #1;
      chk({31'h0, IRQ}, {31'h0, e}, "irq");
   endtask

   // generous bound; the sequence needs well under two thousand cycles
   initial begin
      repeat (20000) @(posedge CLK);
      failures++;
      close_out();
   end

   initial begin
      {AWADDR, ARADDR, WDATA} = '0;
      WSTRB = 4'hF;
      {AWVALID, WVALID, BREADY, ARVALID, RREADY} = '0;
      RST_N = 1'b0;
      repeat (20) @(posedge CLK);
      RST_N <= 1'b1;
      foreach (rows[n]) begin
         if (rows[n].w)
            wr(rows[n].a, rows[n].v);
         else
            rd(rows[n].a);
         chk({30'h0, r}, {30'h0, rows[n].s}, "resp");
         if (!rows[n].w)
            chk(q, rows[n].e, "rdata");
      end
      // drain the packet, then interrupt on packet sent
      so(RD, 0);
      chk(d, 8'hA1, "byte");
      so(RD, 2);
      chk(d, 8'hB2, "byte");
      so(INQ, 0);
      chk(hs, 2'b01, "send");
      so(ADV, 1);
      rc(FLG, 32'hFF, 32'h08);
      rc(IST, 32'h7, 32'h4);
      ck_irq(1'b0);
      wr(IMK, 32'h4);
      ck_irq(1'b1);
      wr(IST, 32'h4);
      ck_irq(1'b0);
      // fill, overrun, locked pointer
      for (int j = 0; j < 16; j++) wr(DAT, 32'h10 + j);
      rc(FLG, 32'hFF, 32'h04);
      wr(DAT, 32'hEE);
      rc(FLG, 32'hFF, 32'h05);
      so(INQ, 5);
      chk(hs, 2'b10, "nak");
      rc(FLG, 32'h01, 32'h01);
      rc(IST, 32'h1, 32'h1);
      wr(FLG, 32'h01);
      rc(FLG, 32'hFF, 32'h04);
      wr(CNT, 32'h10);
      for (int j = 0; j < 16; j++) begin
         so(RD, j % 3);
         chk(d, 8'h10 + j, "byte");
      end
      // one read too many
      so(RD, 0);
      chk(d, 8'h1F, "held");
      rc(FLG, 32'h02, 32'h02);
      rc(IST, 32'h2, 32'h2);
      so(INQ, 0);
      chk(hs, 2'b10, "nak");
      so(REW, 3);
      so(RD, 0);
      chk(d, 8'h1F, "held");
      rc(FLG, 32'h02, 32'h02);
      wr(CTL, 32'h1);
      rc(FLG, 32'hFF, 32'h08);
      wr(IST, 32'h7);
      // count written twice
      wr(DAT, 32'h55);
      wr(CNT, 32'h1);
      // rewind must make the byte readable again without an underrun
      so(RD, 0);
      so(REW, 0);
      so(RD, 0);
      chk(d, 8'h55, "rewound");
      wr(CNT, 32'h3);
      rc(FLG, 32'h43, 32'h41);
      rc(CNT, 32'h1F, 32'h01);
      wr(CTL, 32'h1);
      // count disagrees with bytes written
      wr(DAT, 32'h61);
      wr(DAT, 32'h62);
      wr(CNT, 32'h3);
      rc(FLG, 32'h02, 32'h02);
      wr(CTL, 32'h1);
      rc(FLG, 32'hFF, 32'h08);
      // marker advanced with nothing committed
      so(ADV, 0);
      rc(FLG, 32'h42, 32'h02);
      wr(CTL, 32'h1);
      // lane 0 disabled: the data write must leave the fifo empty
      WSTRB <= 4'h0;
      wr(DAT, 32'h99);
      WSTRB <= 4'hF;
      rc(FLG, 32'hFF, 32'h08);
      // reset in mid-run
      wr(IMK, 32'h7);
      wr(DAT, 32'h77);
      @(posedge CLK);
      RST_N <= 1'b0;
      repeat (3) @(posedge CLK);
      RST_N <= 1'b1;
      rc(FLG, 32'hFF, 32'h08);
      rc(IMK, 32'h7, 32'h0);
      close_out();
   end
endmodule
